// >>> verilog/ctm_pkg.sv
/*
 constants, register map and field layouts of the compact timer.
 assumes a single 125 MHz system clock and an 8-bit register port.
*/
// Overview of operation
// - 10-bit counter steps on each timer tick
// - period code meets bits 9..7, compare-A all
// - software clears counter only via on rising
// - overflow or selected match clears counter
// - pause holds count, release resumes counting
// - clock select picks one of seven tick sources, sub_clk on two codes
// - off holds count, on rising zeroes, runs
// - on rising restores initial output level, except in timer mode
// - period code zero is 1024, else code*128
// - period code zero lets counter overflow
// - clear select: period match or compare-A match
// - mode select: compare, pwm, timer; 01 undefined
// - compare-A match: hold, low, high or toggle
// - match to same level leaves pin unchanged
// - pwm: forced inactive, forced active, waveform
// - initial level or pwm active level bit
// - polarity bit inverts pin in compare and pwm modes only
// - swap bit exchanges period and duty sources
// - second pin is always inverse of first
// - counter read-only pair, compare-A read/write pair
// - low bytes pass through shared holding buffer
// - clear on compare-A suppresses period flag outside pwm mode
// - duty not below period gives full duty
package ctm_pkg;

    // ----------------------------------------------------------------
    // register port
    // ----------------------------------------------------------------
    localparam int REG_ADDR_W = 3;
    localparam logic [2:0] REG_CTL0 = 3'h0;
    localparam logic [2:0] REG_CTL1 = 3'h1;
    localparam logic [2:0] REG_CNT_LO = 3'h2;
    localparam logic [2:0] REG_CNT_HI = 3'h3;
    localparam logic [2:0] REG_CMPA_LO = 3'h4;
    localparam logic [2:0] REG_CMPA_HI = 3'h5;
    localparam logic [2:0] REG_FLAGS = 3'h6;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam int FLG_A = 0;
    localparam int FLG_P = 1;

    // ----------------------------------------------------------------
    // field codes
    // ----------------------------------------------------------------
    localparam logic [2:0] CS_SYS4 = 3'h0;
    localparam logic [2:0] CS_SYS = 3'h1;
    localparam logic [2:0] CS_H16 = 3'h2;
    localparam logic [2:0] CS_H64 = 3'h3;
    localparam logic [2:0] CS_SUB0 = 3'h4;
    localparam logic [2:0] CS_SUB1 = 3'h5;
    localparam logic [2:0] CS_EXT_R = 3'h6;
    localparam logic [2:0] CS_EXT_F = 3'h7;
    localparam logic [1:0] MD_CMP = 2'h0;
    localparam logic [1:0] MD_PWM = 2'h2;
    localparam logic [1:0] MD_TC = 2'h3;
    localparam logic [1:0] IO_NONE = 2'h0;
    localparam logic [1:0] IO_LOW = 2'h1;
    localparam logic [1:0] IO_HIGH = 2'h2;
    localparam logic [1:0] IO_TOG = 2'h3;
    localparam logic [1:0] IO_INACT = 2'h0;
    localparam logic [1:0] IO_ACT = 2'h1;
    localparam logic [1:0] IO_WAVE = 2'h2;

    // ----------------------------------------------------------------
    // dividers
    // ----------------------------------------------------------------
    localparam logic [1:0] SYS4_LAST = 2'h3;
    localparam logic [3:0] H16_LAST = 4'hF;
    localparam logic [5:0] H64_LAST = 6'h3F;

    typedef struct packed {
        logic pause_control;
        logic [2:0] clock_select;
        logic counter_on;
        logic [2:0] period_compare_value;
    } ctm_ctl0_type;

    typedef struct packed {
        logic [1:0] operating_mode_select;
        logic [1:0] output_function_select;
        logic output_initial_level;
        logic output_polarity;
        logic period_duty_swap;
        logic counter_clear_select;
    } ctm_ctl1_type;

endpackage

// >>> verilog/ctm_compact_timer.sv
/*
 compact timer: 10-bit up counter, period and compare-A comparators,
 compare/pwm/timer modes, complementary output pin pair.
 assumes high_clk, sub_clk and external_clock_input are asynchronous
 and much slower than clk; registers are reached over a plain port.
*/
`timescale 1ns/100ps
module ctm_compact_timer
    import ctm_pkg::*;
#(
    parameter int CNT_W = 10
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [REG_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic high_clk,
    input wire logic sub_clk,
    input wire logic external_clock_input,
    output logic timer_output,
    output logic timer_output_inverted,
    output logic compare_a_flag,
    output logic period_match_flag
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    // the high byte must hold the upper counter bits
    if (CNT_W < 9 || CNT_W > 16) begin : g_bad_width
        $error("ctm_compact_timer: CNT_W must lie in 9..16");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [2:0] a,
                                 input logic [2:0] idx);
        hit = (a == idx);
    endfunction

    // period length in ticks, code zero means full wrap
    function automatic logic [CNT_W:0] prd_len(input logic [2:0] rp);
        logic [CNT_W:0] r;
        r = '0;
        if (rp == 3'h0) begin
            r[CNT_W] = 1'b1;
        end else begin
            r[CNT_W-1 -: 3] = rp;
        end
        prd_len = r;
    endfunction

    function automatic logic [CNT_W:0] a_len(input logic [CNT_W-1:0] a);
        logic [CNT_W:0] r;
        r = {1'b0, a};
        if (a == '0) begin
            r[CNT_W] = 1'b1;
        end
        a_len = r;
    endfunction

    function automatic logic [7:0] hi_byte(input logic [CNT_W-1:0] v);
        logic [7:0] r;
        r = '0;
        r[CNT_W-9:0] = v[CNT_W-1:8];
        hi_byte = r;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    ctm_ctl0_type ctl0_q;
    ctm_ctl1_type ctl1_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cmpa_q;
    logic [7:0] hold_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] prev_q;
    logic [1:0] sys_div_q;
    logic [5:0] h_div_q;
    logic out_lvl_q;

    logic h_rise, sub_rise, ext_rise, ext_fall;
    logic tick_w, run_w, on_w, pause_w, on_rise_w;
    logic pwm_w, cclr_w, swap_w;
    logic [CNT_W:0] nxt_w, plen_w, alen_w, duty_w, per_w;
    logic p_hit_w, a_hit_w, clr_w, p_set_w, a_set_w;
    logic active_w, pwm_lvl_w, act_pin_w, full_w;
    logic [7:0] cnt_lo_w;
    logic [CNT_W-9:0] wd_hi_w;

    assign on_w = ctl0_q.counter_on;
    assign pause_w = ctl0_q.pause_control;
    assign run_w = on_w & ~pause_w;
    assign pwm_w = (ctl1_q.operating_mode_select == MD_PWM);
    assign cclr_w = ctl1_q.counter_clear_select;
    assign swap_w = ctl1_q.period_duty_swap;
    assign cnt_lo_w = cnt_q[7:0];
    assign wd_hi_w = reg_wdata[CNT_W-9:0];
    // software counter clear only through a 0 to 1 write of the on bit
    assign on_rise_w = reg_wr & hit(reg_addr, REG_CTL0)
                     & reg_wdata[3] & ~on_w;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl0_q <= CTL_RESET;
        end else if (reg_wr && hit(reg_addr, REG_CTL0)) begin
            ctl0_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl1_q <= CTL_RESET;
        end else if (reg_wr && hit(reg_addr, REG_CTL1)) begin
            ctl1_q <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // low byte holding buffer and compare-A pair
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= '0;
        end else if (reg_wr && hit(reg_addr, REG_CMPA_LO)) begin
            hold_q <= reg_wdata;
        end else if (reg_rd && hit(reg_addr, REG_CNT_HI)) begin
            hold_q <= cnt_q[7:0];
        end else if (reg_rd && hit(reg_addr, REG_CMPA_HI)) begin
            hold_q <= cmpa_q[7:0];
        end
    end

    // the low byte lands only when the high byte is written
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmpa_q <= '0;
        end else if (reg_wr && hit(reg_addr, REG_CMPA_HI)) begin
            cmpa_q <= {wd_hi_w, hold_q};
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // low bytes read the buffer, so the high byte must be read first
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTL0: reg_rdata <= ctl0_q;
                REG_CTL1: reg_rdata <= ctl1_q;
                REG_CNT_LO: reg_rdata <= hold_q;
                REG_CNT_HI: reg_rdata <= hi_byte(cnt_q);
                REG_CMPA_LO: reg_rdata <= hold_q;
                REG_CMPA_HI: reg_rdata <= hi_byte(cmpa_q);
                REG_FLAGS: reg_rdata <= {6'h00, period_match_flag,
                                         compare_a_flag};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ----------------------------------------------------------------
    // tick sources
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= {external_clock_input, sub_clk, high_clk};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign h_rise = sync2_q[0] & ~prev_q[0];
    assign sub_rise = sync2_q[1] & ~prev_q[1];
    assign ext_rise = sync2_q[2] & ~prev_q[2];
    assign ext_fall = ~sync2_q[2] & prev_q[2];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sys_div_q <= '0;
        end else begin
            sys_div_q <= sys_div_q + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            h_div_q <= '0;
        end else if (h_rise) begin
            h_div_q <= h_div_q + 6'h01;
        end
    end

    always_comb begin
        case (ctl0_q.clock_select)
            CS_SYS4: tick_w = (sys_div_q == SYS4_LAST);
            CS_SYS: tick_w = 1'b1;
            CS_H16: tick_w = h_rise & (h_div_q[3:0] == H16_LAST);
            CS_H64: tick_w = h_rise & (h_div_q == H64_LAST);
            CS_SUB0, CS_SUB1: tick_w = sub_rise;
            CS_EXT_R: tick_w = ext_rise;
            CS_EXT_F: tick_w = ext_fall;
            default: tick_w = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // comparators
    // ----------------------------------------------------------------
    assign nxt_w = {1'b0, cnt_q} + 1'b1;
    assign plen_w = prd_len(ctl0_q.period_compare_value);
    assign alen_w = a_len(cmpa_q);
    // a match is seen on the tick that would reach the value,
    // so the count runs 0..len-1 and the period is len ticks
    assign p_hit_w = (nxt_w == plen_w);
    assign a_hit_w = (nxt_w == alen_w);
    always_comb begin
        if (pwm_w) begin
            clr_w = swap_w ? a_hit_w : p_hit_w;
        end else begin
            clr_w = cclr_w ? a_hit_w : p_hit_w;
        end
    end
    assign p_set_w = tick_w & run_w & p_hit_w
                   & (pwm_w | ~cclr_w);
    // an all-zero compare-A only wraps and raises nothing
    assign a_set_w = tick_w & run_w & a_hit_w & (cmpa_q != '0);

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
        end else if (on_rise_w) begin
            cnt_q <= '0;
        end else if (tick_w && run_w) begin
            if (clr_w) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= nxt_w[CNT_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // sticky match flags, write one to clear, set wins
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            compare_a_flag <= 1'b0;
            period_match_flag <= 1'b0;
        end else begin
            compare_a_flag <= a_set_w | (compare_a_flag & ~(reg_wr
                & hit(reg_addr, REG_FLAGS) & reg_wdata[FLG_A]));
            period_match_flag <= p_set_w | (period_match_flag & ~(reg_wr
                & hit(reg_addr, REG_FLAGS) & reg_wdata[FLG_P]));
        end
    end

    // ----------------------------------------------------------------
    // pwm waveform
    // ----------------------------------------------------------------
    assign per_w = swap_w ? alen_w : plen_w;
    assign duty_w = swap_w ? plen_w : alen_w;
    // duty at or above period keeps the level active all period
    assign active_w = ({1'b0, cnt_q} < duty_w);
    always_comb begin
        case (ctl1_q.output_function_select)
            IO_INACT: pwm_lvl_w = ~ctl1_q.output_initial_level;
            IO_ACT: pwm_lvl_w = ctl1_q.output_initial_level;
            IO_WAVE: pwm_lvl_w = ~(active_w
                                 ^ ctl1_q.output_initial_level);
            default: pwm_lvl_w = ~ctl1_q.output_initial_level;
        endcase
    end
    assign act_pin_w = ctl1_q.output_initial_level ^ ctl1_q.output_polarity;
    assign full_w = pwm_w & (ctl1_q.output_function_select == IO_WAVE)
                  & (duty_w >= per_w) & ({1'b0, cnt_q} < per_w);

    // ----------------------------------------------------------------
    // compare-match output level
    // ----------------------------------------------------------------
    // driving the level already held looks like no change on the pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_lvl_q <= 1'b0;
        end else if (on_rise_w && ctl1_q.operating_mode_select != MD_TC) begin
            out_lvl_q <= ctl1_q.output_initial_level;
        end else if (ctl1_q.operating_mode_select == MD_CMP && a_set_w) begin
            case (ctl1_q.output_function_select)
                IO_LOW: out_lvl_q <= 1'b0;
                IO_HIGH: out_lvl_q <= 1'b1;
                IO_TOG: out_lvl_q <= ~out_lvl_q;
                default: out_lvl_q <= out_lvl_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output pins
    // ----------------------------------------------------------------
    // timer mode and the undefined mode just hold the last level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_output <= 1'b0;
            timer_output_inverted <= 1'b1;
        end else if (pwm_w) begin
            timer_output <= pwm_lvl_w ^ ctl1_q.output_polarity;
            timer_output_inverted <= ~(pwm_lvl_w
                                     ^ ctl1_q.output_polarity);
        end else if (ctl1_q.operating_mode_select == MD_CMP) begin
            timer_output <= out_lvl_q ^ ctl1_q.output_polarity;
            timer_output_inverted <= ~(out_lvl_q
                                     ^ ctl1_q.output_polarity);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_cnt_hi_rd;
        reg_rd && reg_addr == REG_CNT_HI;
    endsequence
    sequence s_cnt_lo_rd;
        reg_rd && reg_addr == REG_CNT_LO;
    endsequence
    sequence s_a_lo_wr;
        reg_wr && reg_addr == REG_CMPA_LO;
    endsequence
    sequence s_a_hi_wr;
        reg_wr && reg_addr == REG_CMPA_HI;
    endsequence

    chk_on_rise_clear: assert property (
        $rose(on_w) |-> cnt_q == '0)
        else $error("counter not zero after on rising");
    chk_off_hold: assert property (
        !on_w && !$past(on_w) |-> $stable(cnt_q))
        else $error("counter moved while off");
    chk_pause_hold: assert property (
        pause_w && $past(pause_w) && on_w && $past(on_w) |-> $stable(cnt_q))
        else $error("counter moved while paused");
    chk_period_clear: assert property (
        tick_w && run_w && p_hit_w && !pwm_w && !cclr_w |=> cnt_q == '0)
        else $error("period match did not clear counter");
    chk_ccl_no_pflag: assert property (
        $rose(period_match_flag) |-> !$past(cclr_w) || $past(pwm_w))
        else $error("period flag raised with compare-A clear");
    chk_inv_pair: assert property (
        timer_output_inverted == !timer_output)
        else $error("output pair not complementary");
    chk_cnt_pair_read: assert property (
        s_cnt_hi_rd ##1 (!reg_wr && !reg_rd) ##1 s_cnt_lo_rd |=> reg_rdata == $past(cnt_lo_w, 3))
        else $error("counter low byte not from buffer");
    chk_cmpa_commit: assert property (
        s_a_lo_wr ##1 (!reg_wr && !reg_rd) ##1 s_a_hi_wr |=>
            cmpa_q == {$past(wd_hi_w), $past(reg_wdata, 3)})
        else $error("compare-A pair not committed");
    chk_cmp_toggle: assert property (
        ctl1_q.operating_mode_select == MD_CMP && a_set_w && !on_rise_w
        && ctl1_q.output_function_select == IO_TOG
        |=> out_lvl_q != $past(out_lvl_q))
        else $error("toggle on match did not happen");
    chk_pwm_full: assert property (
        $past(full_w) |-> timer_output == $past(act_pin_w))
        else $error("full duty pwm not active");

endmodule

// >>> test/ctm_pin_model.sv
/*
 far side of the compact timer: slow clock sources and the event pin.
 assumes ext_go is raised for one clk cycle to start a burst of ext_n pulses.
*/
`timescale 1ns/100ps
module ctm_pin_model (
    input wire logic clk,
    input wire logic ext_go,
    input wire logic [7:0] ext_n,
    output logic high_clk,
    output logic sub_clk,
    output logic external_clock_input
);
    logic go_q;
    int left;
    int phase;
    initial begin
        high_clk = 1'b0;
        sub_clk = 1'b0;
        external_clock_input = 1'b0;
        go_q = 1'b0;
        left = 0;
        phase = 0;
    end
    always #10 high_clk = ~high_clk;
    always #50 sub_clk = ~sub_clk;
    // ----------------------------------------------------------------
    // event pin
    // ----------------------------------------------------------------
    // idles low outside a burst; each pulse is 8 clk high, 8 clk low
    always @(posedge clk) begin
        go_q <= ext_go;
        if (ext_go && !go_q) begin
            left <= 2 * ext_n;
            phase <= 0;
        end else if (left > 0) begin
            phase <= (phase == 7) ? 0 : phase + 1;
            if (phase == 7) begin
                external_clock_input <= ~external_clock_input;
                left <= left - 1;
            end
        end
    end
endmodule

// >>> test/compact_timer_module_bench.sv
/*
 self-checking bench: register port master and one task per scenario.
 assumes ctm_pin_model drives the slow clocks and the event pin.
*/
`timescale 1ns/100ps
module compact_timer_module_bench;
    import ctm_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ext_go = 1'b0;
    logic [7:0] ext_n = 8'h00;
    logic [7:0] reg_rdata;
    logic high_clk, sub_clk, external_clock_input;
    logic timer_output, timer_output_inverted, compare_a_flag, period_match_flag;
    int failures = 0;
    int num_checks = 0;
    always #4 clk = ~clk;
    ctm_compact_timer uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .high_clk(high_clk), .sub_clk(sub_clk), .external_clock_input(external_clock_input),
        .timer_output(timer_output), .timer_output_inverted(timer_output_inverted),
        .compare_a_flag(compare_a_flag), .period_match_flag(period_match_flag));
    ctm_pin_model pins (.clk(clk), .ext_go(ext_go), .ext_n(ext_n), .high_clk(high_clk),
        .sub_clk(sub_clk), .external_clock_input(external_clock_input));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_val(input string n, input logic [9:0] e, input logic [9:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_in(input string n, input int lo, input int hi, input logic [10:0] g);
        num_checks++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            failures++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic rd_cnt(output logic [9:0] v);
        logic [7:0] h, l;
        rd(REG_CNT_HI, h);
        rd(REG_CNT_LO, l);
        v = {h[1:0], l};
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // mode and pin function change only while off
    task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
        wr(REG_CTL0, 8'h00);
        wr(REG_CTL1, c1);
        wr(REG_FLAGS, 8'h03);
        wr(REG_CTL0, c0);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] d;
        rd(REG_CTL0, d);
        chk_val("ctl0", {2'h0, CTL_RESET}, {2'h0, d});
        wr(REG_CTL1, 8'ha5);
        rd(REG_CTL1, d);
        chk_val("ctl1", 10'h0a5, {2'h0, d});
        wr(REG_CTL1, 8'h00);
        wr(3'h7, 8'hff);
        rd(3'h7, d);
        chk_val("unmapped", 10'h000, {2'h0, d});
        wr(REG_CNT_HI, 8'h03);
        rd(REG_CNT_HI, d);
        chk_val("cnt_hi", 10'h000, {2'h0, d});
        chk_val("pins", 10'h001, {8'h00, timer_output, timer_output_inverted});
        $display("test reset finished");
    endtask
    task automatic t_period;
        int n, len;
        for (int code = 0; code < 8; code++) begin
            len = (code == 0) ? 1024 : code * 128;
            cfg(8'h00, {1'b0, CS_SYS, 1'b1, 3'(code)});
            n = 0;
            while (period_match_flag !== 1'b1) begin
                @(negedge clk);
                n++;
                if (n > 1100) begin
                    failures++;
                    $display("MISMATCH wait expected flag seen timeout");
                    print_verdict;
                end
            end
            chk_in("period", len - 1, len + 1, 11'(n));
        end
        cyc(20);
        chk_val("p_sticky", 10'h001, {9'h000, period_match_flag});
        chk_val("a_zero", 10'h000, {9'h000, compare_a_flag});
        wr(REG_FLAGS, 8'h02);
        cyc(1);
        chk_val("p_clear", 10'h000, {9'h000, period_match_flag});
        $display("test period finished");
    endtask
    task automatic t_cmp;
        logic [7:0] d;
        logic [1:0] io;
        logic oc, pol, lvl;
        wr(REG_CMPA_LO, 8'h34);
        wr(REG_CMPA_HI, 8'hfe);
        rd(REG_CMPA_HI, d);
        chk_val("cmpa_hi", 10'h002, {2'h0, d});
        rd(REG_CMPA_LO, d);
        chk_val("cmpa_lo", 10'h034, {2'h0, d});
        wr(REG_CMPA_LO, 8'h14);
        wr(REG_CMPA_HI, 8'h00);
        for (int i = 0; i < 8; i++) begin
            io = 2'(i >> 1);
            oc = i[0];
            pol = i[1] ^ i[0];
            cfg({MD_CMP, io, oc, pol, 2'b01}, {1'b0, CS_SYS, 1'b1, 3'h1});
            cyc(5);
            chk_val("pin_init", {9'h000, oc ^ pol}, {9'h000, timer_output});
            cyc(25);
            lvl = (io == IO_NONE) ? oc : (io == IO_LOW) ? 1'b0 : (io == IO_HIGH) ? 1'b1 : ~oc;
            chk_val("pin_match", {9'h000, lvl ^ pol}, {9'h000, timer_output});
            chk_val("pin_pair", {9'h000, ~timer_output}, {9'h000, timer_output_inverted});
        end
        wr(REG_CMPA_LO, 8'h2c);
        wr(REG_CMPA_HI, 8'h01);
        wr(REG_FLAGS, 8'h03);
        cyc(400);
        chk_val("flags", 10'h002, {8'h00, compare_a_flag, period_match_flag});
        $display("test compare finished");
    endtask
    task automatic t_pause;
        logic [9:0] a, b;
        cfg({MD_TC, 6'h00}, {1'b0, CS_SYS, 1'b1, 3'h0});
        cyc(50);
        wr(REG_CTL0, {1'b1, CS_SYS, 1'b1, 3'h0});
        rd_cnt(a);
        cyc(20);
        rd_cnt(b);
        chk_val("paused", a, b);
        wr(REG_CTL0, {1'b0, CS_SYS, 1'b1, 3'h0});
        cyc(10);
        rd_cnt(b);
        chk_in("resumed", a + 10, a + 20, {1'b0, b});
        wr(REG_CTL0, {1'b0, CS_SYS, 1'b0, 3'h0});
        rd_cnt(a);
        cyc(20);
        rd_cnt(b);
        chk_val("off_hold", a, b);
        wr(REG_CTL0, {1'b0, CS_SYS, 1'b1, 3'h0});
        rd_cnt(b);
        chk_in("restart", 0, 6, {1'b0, b});
        $display("test pause finished");
    endtask
    task automatic t_pwm;
        logic [1:0] io [5] = '{IO_WAVE, IO_WAVE, IO_INACT, IO_ACT, IO_WAVE};
        logic dpx [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        logic pol [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        int want [5] = '{32, 128, 0, 128, 96};
        int c;
        wr(REG_CMPA_LO, 8'h20);
        wr(REG_CMPA_HI, 8'h00);
        for (int i = 0; i < 5; i++) begin
            cfg({MD_PWM, io[i], 1'b1, pol[i], dpx[i], 1'b1}, {1'b0, CS_SYS, 1'b1, 3'h1});
            cyc(10);
            c = 0;
            repeat (128) begin
                @(negedge clk);
                c += (timer_output === 1'b1) ? 1 : 0;
            end
            chk_in("pwm_high", want[i], want[i], 11'(c));
        end
        $display("test pwm finished");
    endtask
    task automatic t_ext;
        logic [9:0] v;
        for (int i = 0; i < 2; i++) begin
            cfg({MD_TC, 6'h00}, {1'b0, (i == 1) ? CS_EXT_F : CS_EXT_R, 1'b1, 3'h0});
            ext_n <= 8'h05;
            ext_go <= 1'b1;
            @(posedge clk);
            ext_go <= 1'b0;
            cyc(200);
            rd_cnt(v);
            chk_val("events", 10'h005, v);
        end
        $display("test event finished");
    endtask
    task automatic t_clk;
        int lo [6] = '{146, 598, 13, 2, 45, 45};
        int hi [6] = '{154, 606, 17, 5, 50, 50};
        logic [9:0] v;
        for (int i = 0; i < 6; i++) begin
            cfg({MD_TC, 6'h00}, {1'b0, 3'(i), 1'b1, 3'h0});
            cyc(600);
            wr(REG_CTL0, {1'b0, 3'(i), 1'b0, 3'h0});
            rd_cnt(v);
            chk_in("clk_sel", lo[i], hi[i], {1'b0, v});
        end
        $display("test clock finished");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_period;
        t_cmp;
        t_pause;
        t_pwm;
        t_ext;
        t_clk;
        print_verdict;
    end
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        print_verdict;
    end
endmodule
